// *** hw/edpc_top.sv ***
// energy-detect power control: register, event counters, power state and pulse bursts
`include "edpc_cfg.svh"

module edpc_top #(
    parameter int unsigned IDLE_CYCLES = `EDPC_IDLE_CYCLES,
    parameter int unsigned BURST_LEN = `EDPC_BURST_LEN
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire edpc_pkg::edpc_word_t reg_wdata,
    output edpc_pkg::edpc_word_t reg_rdata,
    input wire logic energy_pin,
    input wire logic data_event_pin,
    input wire logic error_event_pin,
    output logic xcvr_power_up,
    output logic ed_pulse
);
    import edpc_pkg::*;

    localparam int TW = $clog2(IDLE_CYCLES + 1);

    // ***************************************************************
    // decode and input conditioning
    // ***************************************************************
    function automatic logic edpc_addr_hit(input logic [4:0] a);
        return a == `EDPC_ADDR;
    endfunction

    logic [2:0] filt, prev_reg, prev_next;
    logic wr_hit, rd_hit, man, energy, d_evt, e_evt, d_hit, e_hit;
    edpc_thr_t dcnt_inc, ecnt_inc;

    edpc_sync #(.WIDTH(3)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .din({error_event_pin, data_event_pin, energy_pin}),
        .dout(filt)
    );

    // ***************************************************************
    // control, counters and power state
    // ***************************************************************
    logic en_reg, up_reg, dn_reg, bd_reg, pwr_reg, dmet_reg, emet_reg;
    logic en_next, up_next, dn_next, bd_next, pwr_next, dmet_next, emet_next;
    edpc_thr_t ethr_reg, dthr_reg, dcnt_reg, ecnt_reg;
    edpc_thr_t ethr_next, dthr_next, dcnt_next, ecnt_next;
    logic [TW-1:0] idle_reg, idle_next;
    edpc_word_t rdata_reg, rdata_next;
    logic idle_done;

    // events count only while enabled, so a disabled block sees none
    always_comb begin
        wr_hit = reg_wr && edpc_addr_hit(reg_addr);
        rd_hit = reg_rd && edpc_addr_hit(reg_addr);
        man = wr_hit && reg_wdata[`EDPC_MAN_BIT] && en_reg;
        prev_next = filt;
        energy = filt[0];
        d_evt = filt[1] && !prev_reg[1] && en_reg;
        e_evt = filt[2] && !prev_reg[2] && en_reg;
        dcnt_inc = (dcnt_reg == 4'hF) ? dcnt_reg : dcnt_reg + 4'h1;
        ecnt_inc = (ecnt_reg == 4'hF) ? ecnt_reg : ecnt_reg + 4'h1;
        d_hit = d_evt && (dcnt_inc >= dthr_reg);
        e_hit = e_evt && (ecnt_inc >= ethr_reg);
        idle_done = idle_reg == TW'(IDLE_CYCLES - 1);
    end

    // register writes, sticky flags and the power state decision
    always_comb begin
        en_next = en_reg;
        up_next = up_reg;
        dn_next = dn_reg;
        bd_next = bd_reg;
        ethr_next = ethr_reg;
        dthr_next = dthr_reg;
        if (wr_hit) begin
            en_next = reg_wdata[`EDPC_EN_BIT];
            up_next = reg_wdata[`EDPC_UP_BIT];
            dn_next = reg_wdata[`EDPC_DN_BIT];
            bd_next = reg_wdata[`EDPC_BD_BIT];
            ethr_next = reg_wdata[`EDPC_ETHR_HI:`EDPC_ETHR_LO];
            dthr_next = reg_wdata[`EDPC_DTHR_HI:`EDPC_DTHR_LO];
        end
        // read clears, but an event in the same cycle wins
        dmet_next = rd_hit ? 1'b0 : dmet_reg;
        emet_next = rd_hit ? 1'b0 : emet_reg;
        if (d_hit) begin
            dmet_next = 1'b1;
        end
        if (e_hit) begin
            emet_next = 1'b1;
        end
        // counters clear after a quiet spell with no data events
        if (!en_reg || (idle_done && !d_evt)) begin
            dcnt_next = 4'h0;
            ecnt_next = 4'h0;
        end else begin
            dcnt_next = d_evt ? dcnt_inc : dcnt_reg;
            ecnt_next = e_evt ? ecnt_inc : ecnt_reg;
        end
        if (!en_reg || d_evt || idle_done) begin
            idle_next = '0;
        end else begin
            idle_next = idle_reg + TW'(1);
        end
        // error threshold informs only; it never moves the power state
        if (!en_reg) begin
            pwr_next = 1'b1;
        end else if (man) begin
            pwr_next = !pwr_reg;
        end else if (pwr_reg && dn_reg && !energy) begin
            pwr_next = 1'b0;
        end else if (!pwr_reg && up_reg && d_hit) begin
            pwr_next = 1'b1;
        end else begin
            pwr_next = pwr_reg;
        end
        // manual bit is self-clearing and so always reads back as zero
        if (rd_hit) begin
            rdata_next = {en_reg, up_reg, dn_reg, 1'b0, bd_reg, pwr_reg,
                emet_reg, dmet_reg, ethr_reg, dthr_reg};
        end else if (reg_rd) begin
            rdata_next = 16'h0000;
        end else begin
            rdata_next = rdata_reg;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_reg <= `EDPC_EN_RST;
            up_reg <= `EDPC_UP_RST;
            dn_reg <= `EDPC_DN_RST;
            bd_reg <= `EDPC_BD_RST;
            ethr_reg <= `EDPC_THR_RST;
            dthr_reg <= `EDPC_THR_RST;
            pwr_reg <= 1'b1;
            dmet_reg <= 1'b0;
            emet_reg <= 1'b0;
            dcnt_reg <= 4'h0;
            ecnt_reg <= 4'h0;
            idle_reg <= '0;
            rdata_reg <= 16'h0000;
            prev_reg <= 3'h0;
        end else if (ce) begin
            en_reg <= en_next;
            up_reg <= up_next;
            dn_reg <= dn_next;
            bd_reg <= bd_next;
            ethr_reg <= ethr_next;
            dthr_reg <= dthr_next;
            pwr_reg <= pwr_next;
            dmet_reg <= dmet_next;
            emet_reg <= emet_next;
            dcnt_reg <= dcnt_next;
            ecnt_reg <= ecnt_next;
            idle_reg <= idle_next;
            rdata_reg <= rdata_next;
            prev_reg <= prev_next;
        end
    end

    // ***************************************************************
    // pulse burst on each line driver power-up that starts while no burst is running
    // ***************************************************************
    edpc_burst_st_t st_reg, st_next;
    logic [2:0] left_reg, left_next;
    logic pulse_reg, pulse_next;

    // a power-up seen mid-burst is dropped; the burst already running covers it
    always_comb begin
        st_next = st_reg;
        left_next = left_reg;
        pulse_next = 1'b0;
        case (st_reg)
            EDPC_IDLE: begin
                if (pwr_next && !pwr_reg) begin
                    pulse_next = 1'b1;
                    st_next = EDPC_PULSE_HI;
                    left_next = bd_reg ? 3'h1 : 3'(BURST_LEN);
                end
            end
            EDPC_PULSE_HI: begin
                st_next = EDPC_PULSE_LO;
                left_next = left_reg - 3'h1;
            end
            EDPC_PULSE_LO: begin
                if (left_reg == 3'h0) begin
                    st_next = EDPC_IDLE;
                end else begin
                    pulse_next = 1'b1;
                    st_next = EDPC_PULSE_HI;
                end
            end
            default: begin
                st_next = EDPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= EDPC_IDLE;
            left_reg <= 3'h0;
            pulse_reg <= 1'b0;
        end else if (ce) begin
            st_reg <= st_next;
            left_reg <= left_next;
            pulse_reg <= pulse_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign xcvr_power_up = pwr_reg;
    assign ed_pulse = pulse_reg;

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n || !ce);

    sequence s_pulse_pair;
        ed_pulse ##1 !ed_pulse;
    endsequence

    a_disabled_up: assert property (!en_reg |=> xcvr_power_up && dcnt_reg == 4'h0)
        else $error("disabled block not powered up with clear counter");
    a_auto_up_go: assert property (en_reg && !pwr_reg && up_reg && d_hit && !man |=> pwr_reg)
        else $error("auto power-up missed");
    a_auto_down_go: assert property (en_reg && pwr_reg && dn_reg && !energy && !man |=> !pwr_reg)
        else $error("auto power-down missed");
    a_manual_flip: assert property (man |=> pwr_reg != $past(pwr_reg))
        else $error("manual toggle did not flip power state");
    a_burst_four: assert property ($rose(ed_pulse) && st_reg == EDPC_PULSE_HI && !bd_reg &&
        left_reg == 3'(BURST_LEN) |-> s_pulse_pair ##1 s_pulse_pair ##1 s_pulse_pair
        ##1 s_pulse_pair ##1 !ed_pulse)
        else $error("burst is not four pulses");
    a_burst_single: assert property (st_reg == EDPC_IDLE && pwr_next && !pwr_reg && bd_reg
        |=> ed_pulse ##1 !ed_pulse [*2])
        else $error("single pulse mode sent extra pulses");
    a_state_read: assert property (rd_hit |=> reg_rdata[`EDPC_PWR_BIT] == $past(pwr_reg))
        else $error("power state bit wrong on read");
    a_err_flag_set: assert property (e_hit |=> emet_reg)
        else $error("error threshold flag not set");
    a_data_flag_set: assert property (d_hit |=> dmet_reg)
        else $error("data threshold flag not set");
    a_flag_clear: assert property (rd_hit && !d_hit && !e_hit |=> !dmet_reg && !emet_reg)
        else $error("flags not cleared by read");
    a_idle_clear: assert property (en_reg && idle_done && !d_evt |=> dcnt_reg == 4'h0)
        else $error("counter not cleared after idle time");
endmodule

// *** hw/edpc_cfg.svh ***
// offsets, field positions, reset values and timing counts of the energy-detect power control
`ifndef EDPC_CFG_SVH
`define EDPC_CFG_SVH

// ***************************************************************
// register address and field positions
// ***************************************************************
`define EDPC_ADDR 5'h1D
`define EDPC_EN_BIT 15
`define EDPC_UP_BIT 14
`define EDPC_DN_BIT 13
`define EDPC_MAN_BIT 12
`define EDPC_BD_BIT 11
`define EDPC_PWR_BIT 10
`define EDPC_EMET_BIT 9
`define EDPC_DMET_BIT 8
`define EDPC_ETHR_HI 7
`define EDPC_ETHR_LO 4
`define EDPC_DTHR_HI 3
`define EDPC_DTHR_LO 0

// ***************************************************************
// reset values
// ***************************************************************
`define EDPC_EN_RST 1'h0
`define EDPC_UP_RST 1'h1
`define EDPC_DN_RST 1'h1
`define EDPC_BD_RST 1'h0
`define EDPC_THR_RST 4'h1

// ***************************************************************
// timing and counts
// ***************************************************************
`define EDPC_BURST_LEN 4
`define EDPC_IDLE_TIME_MS 2000
`define EDPC_CLK_KHZ 40000
`define EDPC_IDLE_CYCLES (`EDPC_IDLE_TIME_MS * `EDPC_CLK_KHZ)

`endif

// *** hw/edpc_pkg.sv ***
// types shared by the energy-detect power control files
package edpc_pkg;
    typedef logic [15:0] edpc_word_t;
    typedef logic [3:0] edpc_thr_t;
    typedef enum logic [1:0] {EDPC_IDLE, EDPC_PULSE_HI, EDPC_PULSE_LO} edpc_burst_st_t;
endpackage

// *** hw/edpc_sync.sv ***
// three-stage input synchroniser with agreement filter
module edpc_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    import edpc_pkg::*;

    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    logic [WIDTH-1:0] s1_next, s2_next, s3_next, filt_next;

    // a bit follows the line only once stages two and three agree
    always_comb begin
        s1_next = din;
        s2_next = s1_reg;
        s3_next = s2_reg;
        filt_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);
    end

    // stage one feeds stage two only, so metastability stays contained
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            filt_reg <= '0;
        end else if (ce) begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            filt_reg <= filt_next;
        end
    end

    assign dout = filt_reg;
endmodule

// *** bench/edpc_link_partner.sv ***
// remote link partner model: line energy level and event pulses seen on the cable
module edpc_link_partner (
    input wire logic clk,
    output logic energy,
    output logic data_ev,
    output logic err_ev
);
    timeunit 1ns;
    timeprecision 100ps;

    // lines idle low until the bench asks for traffic
    initial begin
        energy = 1'b0;
        data_ev = 1'b0;
        err_ev = 1'b0;
    end

    // raise or drop carrier energy on the line
    task automatic set_energy(input logic v);
        @(posedge clk);
        energy <= v;
    endtask

    // four clocks per level so the input filter never drops an event
    task automatic pulse(input bit err, input int n);
        repeat (n) begin
            @(posedge clk);
            if (err) begin
                err_ev <= 1'b1;
            end else begin
                data_ev <= 1'b1;
            end
            repeat (4) @(posedge clk);
            err_ev <= 1'b0;
            data_ev <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule

// *** bench/energy_detect_power_control_tb_top.sv ***
// self-checking bench of the energy-detect power control
module energy_detect_power_control_tb_top import edpc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // short idle timer keeps the run brief
    localparam int IDLE = 50;
    localparam int BURST = 4;
    localparam logic [4:0] CTL = 5'h1D;
    logic clk, arst_n, ce, reg_wr, reg_rd, energy_pin, data_event_pin, error_event_pin;
    logic xcvr_power_up, ed_pulse;
    logic [4:0] reg_addr;
    edpc_word_t reg_wdata, reg_rdata, rd;
    int n_fail, total_checks, pulses, dthr, ethr;

    edpc_top #(.IDLE_CYCLES(IDLE), .BURST_LEN(BURST)) dut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .energy_pin(energy_pin), .data_event_pin(data_event_pin),
        .error_event_pin(error_event_pin), .xcvr_power_up(xcvr_power_up),
        .ed_pulse(ed_pulse)
    );

    edpc_link_partner lp (
        .clk(clk), .energy(energy_pin), .data_ev(data_event_pin), .err_ev(error_event_pin)
    );

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // pulses are one cycle wide, so counting high cycles counts pulses
    always @(posedge clk) begin
        if (ed_pulse === 1'b1) pulses++;
    end

    // ***************************************************************
    // expectations and bus cycles
    // ***************************************************************
    function automatic edpc_word_t ctl(logic en, logic up, logic dn, logic man, logic bd,
                                       edpc_thr_t e, edpc_thr_t d);
        return {en, up, dn, man, bd, 3'h0, e, d};
    endfunction

    function automatic edpc_word_t burst(logic bd);
        return bd ? 16'h0001 : 16'(BURST);
    endfunction

    task automatic chk(input edpc_word_t got, input edpc_word_t exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input edpc_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data is registered, so it is taken just after the edge that follows the strobe
    task automatic rd_reg(input logic [4:0] a, output edpc_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // bounded wait for the power state; running out ends the run
    task automatic wait_pwr(input logic v);
        // look a little after each edge so the state launched there has settled
        for (int i = 0; i < 40 && xcvr_power_up !== v; i++) begin
            @(posedge clk);
            #1;
        end
        chk({15'h0, xcvr_power_up}, {15'h0, v});
        if (xcvr_power_up !== v) test_done();
    endtask

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        n_fail = 0;
        total_checks = 0;
        pulses = 0;
        void'($urandom(31));
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        // reset word; power state masked as it means nothing while disabled
        rd_reg(CTL, rd);
        chk(rd & 16'hFBFF, 16'h6011);
        chk({15'h0, xcvr_power_up}, 16'h0001);
        // unmapped place: write ignored, read zero
        wr(5'h1C, 16'hFFFF);
        rd_reg(5'h1C, rd);
        chk(rd, 16'h0000);
        // random data threshold, at least two so a partial count shows
        dthr = 2 + $urandom_range(3);
        wr(CTL, ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h1, edpc_thr_t'(dthr)));
        wait_pwr(1'b0);
        lp.set_energy(1'b1);
        lp.pulse(1'b0, dthr - 1);
        repeat (10) @(posedge clk);
        chk({15'h0, xcvr_power_up}, 16'h0000);
        pulses = 0;
        lp.pulse(1'b0, 1);
        wait_pwr(1'b1);
        repeat (12) @(posedge clk);
        chk(16'(pulses), burst(1'b0));
        rd_reg(CTL, rd);
        chk(rd & 16'h0500, 16'h0500);
        rd_reg(CTL, rd);
        chk(rd & 16'h0100, 16'h0000);
        // a partial count must be forgotten after the idle time
        lp.set_energy(1'b0);
        wait_pwr(1'b0);
        repeat (IDLE + 20) @(posedge clk);
        lp.set_energy(1'b1);
        lp.pulse(1'b0, dthr - 1);
        repeat (IDLE + 20) @(posedge clk);
        lp.pulse(1'b0, 1);
        repeat (10) @(posedge clk);
        chk({15'h0, xcvr_power_up}, 16'h0000);
        // manual toggle with automatic actions off and single pulses
        ethr = 1 + $urandom_range(2);
        wr(CTL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, edpc_thr_t'(ethr), edpc_thr_t'(dthr)));
        pulses = 0;
        wr(CTL, ctl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, edpc_thr_t'(ethr), edpc_thr_t'(dthr)));
        wait_pwr(1'b1);
        repeat (8) @(posedge clk);
        chk(16'(pulses), burst(1'b1));
        rd_reg(CTL, rd);
        chk(rd & 16'hFCFF, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, edpc_thr_t'(ethr),
            edpc_thr_t'(dthr)) | 16'h0400);
        // a data event restarts the idle timer before the error burst
        lp.pulse(1'b0, 1);
        lp.pulse(1'b1, ethr);
        repeat (10) @(posedge clk);
        rd_reg(CTL, rd);
        chk(rd & 16'h0600, 16'h0600);
        // clock enable low freezes the block, so a toggle written meanwhile is lost
        @(posedge clk);
        ce <= 1'b0;
        wr(CTL, ctl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, edpc_thr_t'(ethr), edpc_thr_t'(dthr)));
        repeat (4) @(posedge clk);
        chk({15'h0, xcvr_power_up}, 16'h0001);
        ce <= 1'b1;
        wr(CTL, ctl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, edpc_thr_t'(ethr), edpc_thr_t'(dthr)));
        wait_pwr(1'b0);
        // disabled: transceiver back up and events ignored
        wr(CTL, ctl(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h1, 4'h1));
        wait_pwr(1'b1);
        lp.pulse(1'b0, 1);
        repeat (10) @(posedge clk);
        rd_reg(CTL, rd);
        chk(rd & 16'h0300, 16'h0000);
        test_done();
    end
endmodule
